// >>> common/transceiver_monitor_pkg.sv
// Package: command codes, flag layouts, masks and carrier types of the monitor
package transceiver_monitor_pkg;

   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_LASER_TEMP    = 8'h11;
   localparam logic [7:0] CMD_MODULE_TEMP   = 8'h12;
   localparam logic [7:0] CMD_LASER_BIAS    = 8'h13;
   localparam logic [7:0] CMD_LASER_SWING   = 8'h14;
   localparam logic [7:0] CMD_TX_POWER      = 8'h15;
   localparam logic [7:0] CMD_RX_POWER      = 8'h16;
   localparam logic [7:0] CMD_PD_VOLTAGE    = 8'h17;
   localparam logic [7:0] CMD_RSV_FIRST     = 8'h18;
   localparam logic [7:0] CMD_RSV_LAST      = 8'h1C;
   localparam logic [7:0] CMD_CONDITION     = 8'h1D;
   localparam logic [7:0] CMD_FAULT_FLAGS   = 8'h1E;
   localparam logic [7:0] CMD_WARNING_FLAGS = 8'h1F;
   localparam logic [7:0] CMD_WARN_MASK_WR  = 8'h20;
   localparam logic [7:0] CMD_WARN_MASK_RD  = 8'h21;
   localparam logic [7:0] CMD_TX_RESET      = 8'h29;
   localparam logic [7:0] CMD_RX_RESET      = 8'h2A;

   // ------------------------------------------------------------
   // Condition byte bit positions
   // ------------------------------------------------------------
   localparam int COND_LASER_BIT    = 7;
   localparam int COND_ALARM_BIT    = 6;
   localparam int COND_WARNING_BIT  = 5;
   localparam int COND_DISABLED_BIT = 4;
   localparam int COND_VENDOR_W     = 4;

   // ------------------------------------------------------------
   // Fault flag groups (bit7 temp high, bit6 temp low, bit5/4
   // wavelength, bit3/2 tx power, bit1 pd supply, bit0 start-up)
   // ------------------------------------------------------------
   localparam logic [7:0] FAULT_TEMP_BITS   = 8'hC0;
   localparam logic [7:0] FAULT_TX_ONLY     = 8'h3D;
   localparam logic [7:0] FAULT_RX_ONLY     = 8'h02;
   localparam logic [7:0] FAULT_TX_PATH     = 8'hFD;
   localparam logic [7:0] FAULT_RX_PATH     = 8'hC2;
   localparam logic [7:0] FAULT_WARMUP_OK   = 8'hC1;
   localparam logic [7:0] ALL_ONES          = 8'hFF;

   // ------------------------------------------------------------
   // Warning groups and mask reset
   // ------------------------------------------------------------
   localparam logic [7:0] WARN_TX_PATH      = 8'hF1;
   localparam logic [7:0] WARN_RX_PATH      = 8'h6E;
   localparam logic [7:0] WARN_MASK_RESET   = 8'hFF;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] laser_temp;
      logic [15:0] module_temp;
      logic [15:0] laser_bias;
      logic [15:0] laser_swing;
      logic [15:0] tx_power;
      logic [15:0] rx_power;
      logic [15:0] pd_voltage;
   } meas_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [7:0] operand;
   } cmd_t;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } resp_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FIRST = 2'b01,
      ST_LAST  = 2'b11
   } resp_state_t;

endpackage : transceiver_monitor_pkg

// >>> design/level_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // ------------------------------------------------------------
   // Stages
   // ------------------------------------------------------------
   // First stage is read by the second stage only
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule : level_sync

// >>> design/sticky_flags.sv
// Sticky flag bank: hardware sets, clear strobes drop bits, set wins a tie
module sticky_flags #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   // Set and clear
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   logic [WIDTH-1:0] flags_r;
   logic [WIDTH-1:0] flags_nxt;

   // ------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------
   // Reading never clears; a set in the clear cycle is kept
   always_comb begin
      flags_nxt = (flags_r & ~clear_in) | set_in;
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_out = flags_r;

endmodule : sticky_flags

// >>> design/transceiver_monitor_alarm.sv
// Live data readout, condition byte, fault flags and fault pins of the module
//
// How it works
// - Laser temperature: two bytes, low first
// - Module temperature: signed 16-bit, low first
// - Bias and swing current: unsigned, low first
// - Transmit power: unsigned microwatts, low first
// - Receive power: unsigned tenth microwatts, low first
// - Photodiode supply voltage: unsigned, low first
// - Codes 18h-1Ch reserved, no function
// - Condition command answers exactly one byte
// - Condition bits: laser, alarm, warning, disabled, vendor
// - Laser bit one while emitting light
// - Any alarm; only enabled warnings set warning
// - Disabled bit is inverse of enable pin
// - Alarms or enabled warnings raise fault pins
// - Deasserted enable also raises fault pins
// - Alarms unmasked, shut down their own path
// - Temperature high/low bits shut down both paths
// - Wavelength and power bits shut transmitter only
// - Supply voltage bit shuts receiver only
// - Start-up timeout: transmitter; receiver failure: RX pin
// - Temperature shutdown needs both reset commands
// - Warm-up passes only timeout, temperature and receiver failure alarms
// - Warnings ANDed with host enable mask
// - Mask all ones at reset and path resets
module transceiver_monitor_alarm
   import transceiver_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic                              clock_in,
   input  wire logic                              resetn_in,
   // Command port from the management bus front end
   input  wire transceiver_monitor_pkg::cmd_t     cmd_in,
   output logic                                   cmd_ready_out,
   output logic                                   cmd_refused_out,
   // Response byte stream
   output transceiver_monitor_pkg::resp_t         resp_out,
   input  wire logic                              resp_ready_in,
   // Live measurements and conditions from module logic
   input  wire transceiver_monitor_pkg::meas_t    meas_in,
   input  wire logic [7:0]                        alarm_cond_in,
   input  wire logic                              rx_startup_fail_in,
   input  wire logic [7:0]                        warning_cond_in,
   input  wire logic                              warm_up_in,
   input  wire logic                              laser_emitting_in,
   input  wire logic [3:0]                        vendor_status_in,
   // Module enable pin
   input  wire logic                              module_enable_in,
   // Fault pins and path shutdown
   output logic                                   tx_fault_out,
   output logic                                   rx_fault_out,
   output logic                                   tx_shutdown_out,
   output logic                                   rx_shutdown_out
);
   import transceiver_monitor_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic [1:0] rst_pipe_r;
   logic       rst_n;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_pipe_r <= 2'b00;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe_r[1];

   // ------------------------------------------------------------
   // Enable pin synchroniser
   // ------------------------------------------------------------
   logic enable_sync;

   level_sync #(
      .WIDTH (1)
   ) u_enable_sync (
      .clock_in (clock_in),
      .rst_n_in (rst_n),
      .async_in (module_enable_in),
      .sync_out (enable_sync)
   );

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Answer length in bytes: 0 for none
   function automatic logic [1:0] answer_len(input logic [7:0] code);
      logic [1:0] len;
      len = 2'd0;
      if (code >= CMD_LASER_TEMP && code <= CMD_PD_VOLTAGE) begin
         len = 2'd2;
      end else if (code >= CMD_CONDITION && code <= CMD_WARNING_FLAGS) begin
         len = 2'd1;
      end else if (code == CMD_WARN_MASK_RD) begin
         len = 2'd1;
      end
      return len;
   endfunction : answer_len

   // Codes this block accepts at all; reserved live-data codes are refused
   function automatic logic is_known(input logic [7:0] code);
      logic known;
      known = 1'b0;
      if (answer_len(code) != 2'd0) begin
         known = 1'b1;
      end else if (code == CMD_WARN_MASK_WR || code == CMD_TX_RESET ||
                   code == CMD_RX_RESET) begin
         known = 1'b1;
      end
      if (code >= CMD_RSV_FIRST && code <= CMD_RSV_LAST) begin
         known = 1'b0;
      end
      return known;
   endfunction : is_known

   // ------------------------------------------------------------
   // Command acceptance
   // ------------------------------------------------------------
   logic cmd_ready_r;
   logic cmd_take;
   logic tx_reset_cmd;
   logic rx_reset_cmd;
   logic mask_write_cmd;

   assign cmd_take       = cmd_in.valid && cmd_ready_r;
   assign tx_reset_cmd   = cmd_take && (cmd_in.code == CMD_TX_RESET);
   assign rx_reset_cmd   = cmd_take && (cmd_in.code == CMD_RX_RESET);
   assign mask_write_cmd = cmd_take && (cmd_in.code == CMD_WARN_MASK_WR);

   // ------------------------------------------------------------
   // Warning enable mask
   // ------------------------------------------------------------
   logic [7:0] warn_mask_r;
   logic [7:0] warn_enabled;

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         warn_mask_r <= WARN_MASK_RESET;
      end else if (tx_reset_cmd || rx_reset_cmd) begin
         warn_mask_r <= WARN_MASK_RESET;
      end else if (mask_write_cmd) begin
         warn_mask_r <= cmd_in.operand;
      end
   end

   // Warnings are live: they fall away with their cause, no latch
   assign warn_enabled = warning_cond_in & warn_mask_r;

   // ------------------------------------------------------------
   // Alarm flags
   // ------------------------------------------------------------
   logic [7:0] alarm_gate;
   logic [8:0] alarm_set;
   logic [8:0] alarm_clear;
   logic [8:0] alarm_flags;
   logic [7:0] fault_byte;
   logic       rx_start_flag;
   logic       temp_active;
   logic       temp_clear;
   logic       tx_seen_r;
   logic       rx_seen_r;

   // No mask on alarms; warm-up lets only timeout, temperature and receiver failure through
   assign alarm_gate = warm_up_in ? FAULT_WARMUP_OK : ALL_ONES;
   assign alarm_set  = {rx_startup_fail_in, alarm_cond_in & alarm_gate};

   assign temp_active = |(alarm_flags[7:0] & FAULT_TEMP_BITS);
   assign temp_clear  = temp_active && (tx_seen_r || tx_reset_cmd) &&
                        (rx_seen_r || rx_reset_cmd);

   // Remember which reset commands arrived while a temperature alarm stands
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_seen_r <= 1'b0;
         rx_seen_r <= 1'b0;
      end else if (temp_clear || !temp_active) begin
         tx_seen_r <= 1'b0;
         rx_seen_r <= 1'b0;
      end else begin
         tx_seen_r <= tx_seen_r | tx_reset_cmd;
         rx_seen_r <= rx_seen_r | rx_reset_cmd;
      end
   end

   always_comb begin
      alarm_clear = 9'h000;
      if (tx_reset_cmd) begin
         alarm_clear[7:0] = alarm_clear[7:0] | FAULT_TX_ONLY;
      end
      if (rx_reset_cmd) begin
         alarm_clear[7:0] = alarm_clear[7:0] | FAULT_RX_ONLY;
         alarm_clear[8]   = 1'b1;
      end
      if (temp_clear) begin
         alarm_clear[7:0] = alarm_clear[7:0] | FAULT_TEMP_BITS;
      end
   end

   sticky_flags #(
      .WIDTH (9)
   ) u_alarm_flags (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n),
      .set_in    (alarm_set),
      .clear_in  (alarm_clear),
      .flags_out (alarm_flags)
   );

   assign fault_byte    = alarm_flags[7:0];
   assign rx_start_flag = alarm_flags[8];

   // ------------------------------------------------------------
   // Condition byte
   // ------------------------------------------------------------
   logic [7:0] cond_byte;

   always_comb begin
      cond_byte                    = 8'h00;
      cond_byte[COND_LASER_BIT]    = laser_emitting_in;
      cond_byte[COND_ALARM_BIT]    = (|fault_byte) | rx_start_flag;
      cond_byte[COND_WARNING_BIT]  = |warn_enabled;
      cond_byte[COND_DISABLED_BIT] = ~enable_sync;
      cond_byte[COND_VENDOR_W-1:0] = vendor_status_in;
   end

   // ------------------------------------------------------------
   // Fault pins and shutdown
   // ------------------------------------------------------------
   logic tx_fault_r;
   logic rx_fault_r;
   logic tx_shutdown_r;
   logic rx_shutdown_r;

   // Fault pins come up asserted, shutdowns low: the enable pin reads as low until synchronised
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_fault_r    <= 1'b1;
         rx_fault_r    <= 1'b1;
         tx_shutdown_r <= 1'b0;
         rx_shutdown_r <= 1'b0;
      end else begin
         tx_fault_r    <= (|(fault_byte & FAULT_TX_PATH)) |
                          (|(warn_enabled & WARN_TX_PATH)) | ~enable_sync;
         rx_fault_r    <= (|(fault_byte & FAULT_RX_PATH)) | rx_start_flag |
                          (|(warn_enabled & WARN_RX_PATH)) | ~enable_sync;
         tx_shutdown_r <= |(fault_byte & FAULT_TX_PATH);
         rx_shutdown_r <= |(fault_byte & FAULT_RX_PATH);
      end
   end

   // ------------------------------------------------------------
   // Answer selection
   // ------------------------------------------------------------
   logic [15:0] answer_word;

   always_comb begin
      answer_word = 16'h0000;
      case (cmd_in.code)
         CMD_LASER_TEMP:    answer_word = meas_in.laser_temp;
         CMD_MODULE_TEMP:   answer_word = meas_in.module_temp;
         CMD_LASER_BIAS:    answer_word = meas_in.laser_bias;
         CMD_LASER_SWING:   answer_word = meas_in.laser_swing;
         CMD_TX_POWER:      answer_word = meas_in.tx_power;
         CMD_RX_POWER:      answer_word = meas_in.rx_power;
         CMD_PD_VOLTAGE:    answer_word = meas_in.pd_voltage;
         CMD_CONDITION:     answer_word = {8'h00, cond_byte};
         CMD_FAULT_FLAGS:   answer_word = {8'h00, fault_byte};
         CMD_WARNING_FLAGS: answer_word = {8'h00, warning_cond_in};
         CMD_WARN_MASK_RD:  answer_word = {8'h00, warn_mask_r};
         default:           answer_word = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Response sequencer
   // ------------------------------------------------------------
   resp_state_t state_r;
   logic [7:0]  high_byte_r;
   resp_t       resp_r;
   logic        refused_r;
   logic [1:0]  take_len;

   assign take_len = answer_len(cmd_in.code);

   // Word snapshot at acceptance keeps both bytes of one sample together
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         cmd_ready_r <= 1'b0;
         high_byte_r <= 8'h00;
         resp_r      <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               cmd_ready_r <= 1'b1;
               if (cmd_take && take_len != 2'd0) begin
                  cmd_ready_r <= 1'b0;
                  resp_r.valid <= 1'b1;
                  resp_r.data  <= answer_word[7:0];
                  high_byte_r  <= answer_word[15:8];
                  if (take_len == 2'd2) begin
                     resp_r.last <= 1'b0;
                     state_r     <= ST_FIRST;
                  end else begin
                     resp_r.last <= 1'b1;
                     state_r     <= ST_LAST;
                  end
               end
            end
            ST_FIRST: begin
               if (resp_ready_in) begin
                  resp_r.data <= high_byte_r;
                  resp_r.last <= 1'b1;
                  state_r     <= ST_LAST;
               end
            end
            ST_LAST: begin
               if (resp_ready_in) begin
                  resp_r      <= '0;
                  cmd_ready_r <= 1'b1;
                  state_r     <= ST_IDLE;
               end
            end
            default: begin
               resp_r      <= '0;
               cmd_ready_r <= 1'b0;
               state_r     <= ST_IDLE;
            end
         endcase
      end
   end

   // Unknown and reserved codes are dropped with a one-cycle pulse
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         refused_r <= 1'b0;
      end else begin
         refused_r <= cmd_take && !is_known(cmd_in.code);
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cmd_ready_out   = cmd_ready_r;
   assign cmd_refused_out = refused_r;
   assign resp_out        = resp_r;
   assign tx_fault_out    = tx_fault_r;
   assign rx_fault_out    = rx_fault_r;
   assign tx_shutdown_out = tx_shutdown_r;
   assign rx_shutdown_out = rx_shutdown_r;

endmodule : transceiver_monitor_alarm

// >>> tb/host_port_model.sv
// Host controller model: sends one command and takes its answer bytes
module host_port_model
   import transceiver_monitor_pkg::*;
(
   // Clock
   input  wire logic                           clock_in,
   // Command and answer
   output transceiver_monitor_pkg::cmd_t       cmd_out,
   input  wire logic                           cmd_ready_in,
   input  wire transceiver_monitor_pkg::resp_t resp_in,
   output logic                                resp_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_out = '0;
      resp_ready_out = 1'b0;
   end
   // ------------
   // One command, then its answer bytes, low byte first
   // ------------
   task automatic send(input logic [7:0] c, input logic [7:0] op, input int stall,
                       output logic [15:0] v, output int n, output logic ok);
      int   w   = 0;
      logic lst = 1'b0;
      {v, n} = '0;
      @(negedge clock_in);
      cmd_out <= '{1'b1, c, op};
      while (!cmd_ready_in && w < 40) begin
         @(negedge clock_in);
         w++;
      end
      ok = cmd_ready_in;
      @(negedge clock_in);
      // Released lines show the inverse, never a stale command
      cmd_out <= '{1'b0, ~c, ~op};
      w = 0;
      while (!lst && w < 8) begin
         if (resp_in.valid) begin
            if (n == 0) repeat (stall) @(negedge clock_in);
            v[8*n +: 8] = resp_in.data;
            lst = resp_in.last;
            n++;
            resp_ready_out <= 1'b1;
         end
         @(negedge clock_in);
         w++;
      end
      resp_ready_out <= 1'b0;
      ok = ok && (lst || n == 0);
   endtask : send
endmodule : host_port_model

// >>> tb/transceiver_monitor_alarm_checker.sv
// Checker: answer timing, shutdowns and fault pins seen at the monitor's ports
module transceiver_monitor_alarm_checker
   import transceiver_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic                           clock_in,
   input  wire logic                           resetn_in,
   // Command and answer
   input  wire transceiver_monitor_pkg::cmd_t  cmd_in,
   input  wire logic                           cmd_ready_out,
   input  wire logic                           cmd_refused_out,
   input  wire transceiver_monitor_pkg::resp_t resp_out,
   input  wire logic                           resp_ready_in,
   // Conditions and pins
   input  wire logic [7:0]                     alarm_cond_in,
   input  wire logic [7:0]                     warning_cond_in,
   input  wire logic                           warm_up_in,
   input  wire logic                           module_enable_in,
   input  wire logic                           tx_fault_out,
   input  wire logic                           rx_fault_out,
   input  wire logic                           tx_shutdown_out,
   input  wire logic                           rx_shutdown_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       take_w;
   logic       rst_w;
   logic [1:0] age_r;
   logic [7:0] mask_r;
   assign take_w = cmd_in.valid && cmd_ready_out;
   assign rst_w  = take_w && cmd_in.code inside {CMD_TX_RESET, CMD_RX_RESET};
   // Internal reset trails the pin, so alarm checks wait a few edges
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) age_r <= 2'h0;
      else if (age_r != 2'h3) age_r <= age_r + 2'h1;
   end
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) mask_r <= 8'hFF;
      else if (take_w && cmd_in.code == CMD_WARN_MASK_WR) mask_r <= cmd_in.operand;
      else if (rst_w) mask_r <= 8'hFF;
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   chk_reserved_refused: assert property (
      (take_w && cmd_in.code inside {[CMD_RSV_FIRST:CMD_RSV_LAST]}) |-> ##[1:2] cmd_refused_out)
      else $error("reserved code not refused");
   chk_live_low_first: assert property (
      (take_w && cmd_in.code inside {[CMD_LASER_TEMP:CMD_PD_VOLTAGE]})
      |=> resp_out.valid && !resp_out.last && !cmd_ready_out)
      else $error("live read did not start with low byte");
   chk_high_byte_last: assert property (
      (resp_out.valid && !resp_out.last && resp_ready_in) |=> resp_out.valid && resp_out.last)
      else $error("high byte missing after low byte");
   chk_condition_one_byte: assert property (
      (take_w && cmd_in.code == CMD_CONDITION) |=> resp_out.valid && resp_out.last)
      else $error("condition read not a single byte");
   chk_disabled_faults: assert property (
      !module_enable_in [*5] |-> tx_fault_out && rx_fault_out)
      else $error("fault pins low while disabled");
   chk_tx_alarm_shut: assert property (
      (age_r == 2'h3 && |(alarm_cond_in & 8'hFD & (warm_up_in ? 8'hC1 : 8'hFF)))
      |-> ##[1:3] tx_shutdown_out) else $error("transmitter not shut down");
   chk_rx_alarm_shut: assert property (
      (age_r == 2'h3 && |(alarm_cond_in & 8'hC2 & (warm_up_in ? 8'hC1 : 8'hFF)))
      |-> ##[1:3] rx_shutdown_out) else $error("receiver not shut down");
   chk_shut_sticky: assert property (
      $fell(tx_shutdown_out) || $fell(rx_shutdown_out) |-> $past(rst_w, 2) || $past(rst_w, 3))
      else $error("shutdown ended without reset command");
   chk_warning_pin: assert property (
      (age_r == 2'h3 && |(warning_cond_in & mask_r & 8'h6E)) [*4] |-> rx_fault_out)
      else $error("enabled warning left receive fault pin low");
   cov_live_read: cover property (take_w && cmd_in.code == CMD_MODULE_TEMP);
   cov_both_shut: cover property (tx_shutdown_out && rx_shutdown_out);
   cov_refused: cover property (cmd_refused_out);
endmodule : transceiver_monitor_alarm_checker

bind transceiver_monitor_alarm transceiver_monitor_alarm_checker chk (.*);

// >>> tb/tb.sv
// Testbench: live reads, condition byte, warnings, alarms and fault pins
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import transceiver_monitor_pkg::*;
   logic clock_in, resetn_in, cmd_ready_out, cmd_refused_out, resp_ready_in;
   logic rx_startup_fail_in, warm_up_in, laser_emitting_in, module_enable_in;
   logic tx_fault_out, rx_fault_out, tx_shutdown_out, rx_shutdown_out;
   logic [7:0] alarm_cond_in, warning_cond_in, bitv, expv;
   logic [3:0] vendor_status_in;
   logic [15:0] v;
   cmd_t cmd_in;
   resp_t resp_out;
   meas_t meas_in;
   int error_cnt, n_tests, n, refusals, i, b, warm;
   host_port_model host (.clock_in, .cmd_out(cmd_in), .cmd_ready_in(cmd_ready_out),
      .resp_in(resp_out), .resp_ready_out(resp_ready_in));
   transceiver_monitor_alarm uut (.*);
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(negedge clock_in) if (cmd_refused_out === 1'b1) refusals++;
   wire [15:0] pins = {12'h000, tx_shutdown_out, rx_shutdown_out, tx_fault_out, rx_fault_out};
   // ------------
   // Shared tasks
   // ------------
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_tests++;
      if (seen !== want) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic final_report();
      $display("Checks %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic cmd(input logic [7:0] c, input logic [7:0] op = 8'h00, input int stall = 0);
      logic ok;
      host.send(c, op, stall, v, n, ok);
      if (!ok) begin
         error_cnt++;
         final_report();
      end
   endtask : cmd
   task automatic hold(input int k);
      repeat (k) @(negedge clock_in);
   endtask : hold
   // ------------
   // Main sequence
   // ------------
   initial begin
      {resetn_in, rx_startup_fail_in, warm_up_in, alarm_cond_in, warning_cond_in} = '0;
      {laser_emitting_in, module_enable_in, vendor_status_in} = 6'h3A;
      meas_in = {16'hFF38, 16'h0159, 16'h01F4, 16'h8321, 16'h4A5B, 16'hC0DE, 16'h0307};
      hold(2);
      resetn_in = 1'b1;
      hold(6);
      for (i = 0; i < 7; i++) begin
         cmd(CMD_LASER_TEMP + 8'(i), 8'h00, (i % 2) * 3);
         check({8'(n), 8'h00}, 16'h0200);
         check(v, meas_in[16*(6-i) +: 16]);
      end
      for (i = 8'h18; i <= 8'h1C; i++) begin
         b = refusals;
         cmd(8'(i));
         check({8'(n), 8'(refusals - b)}, 16'h0001);
      end
      cmd(CMD_CONDITION, 8'h00, 2);
      check({8'(n), v[7:0]}, 16'h018A);
      {module_enable_in, laser_emitting_in} = 2'b00;
      hold(5);
      check(pins, 16'h0003);
      cmd(CMD_CONDITION);
      check(v, 16'h001A);
      {module_enable_in, laser_emitting_in, warning_cond_in} = 10'h308;
      hold(5);
      check(pins, 16'h0001);
      cmd(CMD_CONDITION);
      check(v, 16'h00AA);
      cmd(CMD_WARN_MASK_WR, 8'hF7);
      hold(3);
      check(pins, 16'h0000);
      cmd(CMD_TX_RESET);
      cmd(CMD_WARN_MASK_RD, 8'h00, 1);
      check(v << 8 | pins, 16'hFF01);
      warning_cond_in = 8'h00;
      for (warm = 0; warm < 2; warm++) begin
         warm_up_in = warm[0];
         for (b = 0; b < 8; b++) begin
            bitv = 8'h01 << b;
            expv = warm_up_in ? (bitv & 8'hC1) : bitv;
            alarm_cond_in = bitv;
            hold(2);
            alarm_cond_in = 8'h00;
            hold(3);
            check(pins, {12'h000, {2{|(expv & 8'hFD),
                  |(expv & 8'hC2)}}});
            cmd(CMD_FAULT_FLAGS);
            check(v, {8'h00, expv});
            cmd(CMD_CONDITION);
            check({15'h0000, v[6]}, {15'h0000, |expv});
            cmd(CMD_TX_RESET);
            cmd(CMD_FAULT_FLAGS);
            check({v[7:0], 6'h00, pins[3:2]},
                  {expv & 8'hC2, 6'h00, |(expv & 8'hC0), |(expv & 8'hC2)});
            cmd(CMD_RX_RESET);
            cmd(CMD_FAULT_FLAGS);
            check(v | pins, 16'h0000);
         end
      end
      {warm_up_in, rx_startup_fail_in} = 2'b01;
      hold(2);
      rx_startup_fail_in = 1'b0;
      hold(3);
      check(pins, 16'h0001);
      cmd(CMD_RX_RESET);
      check(pins, 16'h0000);
      final_report();
   end
endmodule : tb
